// file: design/ulbls_pkg.sv
// Constants for the loopback and line status block
package ulbls_pkg;
    localparam int unsigned DATA_WIDTH = 16;
    localparam int unsigned ADDR_WIDTH = 32;
    localparam logic [31:0] MODEM_LINE_CONTROL_ADDR = 32'h50001110;
    localparam logic [31:0] LINE_CONDITION_FLAGS_ADDR = 32'h50001114;
    localparam logic [31:0] IRQ_STATUS_ADDR = 32'h50001180;
    localparam logic [31:0] IRQ_MASK_ADDR = 32'h50001184;
    localparam int unsigned LOOPBACK_BIT = 4;
    localparam int unsigned TRANSMITTER_EMPTY_BIT = 6;
    localparam int unsigned RX_FIFO_ERROR_BIT = 7;
    localparam logic LOOPBACK_RESET = 1'h0;
    localparam logic TRANSMITTER_EMPTY_RESET = 1'h1;
    localparam int unsigned IRQ_WIDTH = 2;
    localparam int unsigned IRQ_RX_ERROR_BIT = 0;
    localparam int unsigned IRQ_TX_EMPTY_BIT = 1;
    localparam int unsigned RX_FIFO_DEPTH = 16;
endpackage

// file: design/ulbls_tx_empty.sv
// Transmitter empty flag tracking
`timescale 1ns/1ps
`default_nettype none
module ulbls_tx_empty (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic fifoEnable,
    input wire logic txFifoEmpty,
    input wire logic holdingEmpty,
    input wire logic shiftEmpty,
    output logic emptyFlag
);
    typedef struct packed {
        logic flag;
    } ulbls_temt_state_type;

    localparam ulbls_temt_state_type RESET_STATE =
        '{flag: ulbls_pkg::TRANSMITTER_EMPTY_RESET};

    ulbls_temt_state_type r;
    ulbls_temt_state_type rNxt;

    always_comb begin
        rNxt = r;
        if (fifoEnable) begin
            rNxt.flag = shiftEmpty & txFifoEmpty;
        end else begin
            rNxt.flag = shiftEmpty & holdingEmpty;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= RESET_STATE;
        end else if (clkEn) begin
            r <= rNxt;
        end
    end

    assign emptyFlag = r.flag;
endmodule
`default_nettype wire

// file: design/ulbls_rx_err.sv
// Receive FIFO error bookkeeping behind the receive error flag
`timescale 1ns/1ps
`default_nettype none
module ulbls_rx_err #(
    parameter int unsigned DEPTH = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic push,
    input wire logic pushParityErr,
    input wire logic pushStopBitOk,
    input wire logic pushBreak,
    input wire logic pop,
    input wire logic statusRead,
    output logic errFlag
);
    localparam int unsigned PW = $clog2(DEPTH);
    localparam int unsigned CW = PW + 1;

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_badDepth
            $error("DEPTH must be a power of two of at least 2");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0] errMem;
        logic [PW-1:0] wrPtr;
        logic [PW-1:0] rdPtr;
        logic [CW-1:0] count;
        logic [CW-1:0] errCount;
        logic flag;
    } ulbls_rxerr_state_type;

    ulbls_rxerr_state_type r;
    ulbls_rxerr_state_type rNxt;
    logic headErr;
    logic doPush;
    logic doPop;
    logic newErr;

    always_comb begin
        rNxt = r;
        headErr = r.errMem[r.rdPtr];
        doPush = push && (r.count < CW'(DEPTH));
        doPop = pop && (r.count != '0);
        newErr = pushParityErr | ~pushStopBitOk | pushBreak;
        if (doPop) begin
            rNxt.rdPtr = r.rdPtr + 1'b1;
            if (headErr) begin
                rNxt.errCount = rNxt.errCount - 1'b1;
            end
        end
        if (doPush) begin
            rNxt.errMem[r.wrPtr] = newErr;
            rNxt.wrPtr = r.wrPtr + 1'b1;
            if (newErr) begin
                rNxt.errCount = rNxt.errCount + 1'b1;
            end
        end
        rNxt.count = r.count + CW'(doPush) - CW'(doPop);
        // Later errors keep the flag up across the read
        if (statusRead && (r.errCount == '0
                || (headErr && r.errCount == CW'(1)))) begin
            rNxt.flag = 1'b0;
        end
        // A new error wins over a clearing read
        if (doPush && newErr) begin
            rNxt.flag = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
        end else if (clkEn) begin
            r <= rNxt;
        end
    end

    assign errFlag = r.flag;

    property p_rfeSet;
        @(posedge clk) disable iff (!reset_n)
        (clkEn && push && r.count < CW'(DEPTH) && !pushStopBitOk)
            |=> (r.flag && r.errCount != '0);
    endproperty
    a_rfeSet: assert property (p_rfeSet)
        else $error("framing error did not raise the flag");

    property p_rfeKeep;
        @(posedge clk) disable iff (!reset_n)
        (clkEn && statusRead && r.flag && r.errCount > CW'(1))
            |=> r.flag;
    endproperty
    a_rfeKeep: assert property (p_rfeKeep)
        else $error("flag cleared with later errors queued");
endmodule
`default_nettype wire

// file: design/ulbls_top.sv
// Loopback control and line status flags of the serial port
`timescale 1ns/1ps
`default_nettype none
module ulbls_top #(
    parameter int unsigned RX_DEPTH = ulbls_pkg::RX_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic [ulbls_pkg::ADDR_WIDTH-1:0] regAddr,
    input wire logic [ulbls_pkg::DATA_WIDTH-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [ulbls_pkg::DATA_WIDTH-1:0] regRdData,
    output logic irq,
    output logic loopbackActive,
    input wire logic fifoEnable,
    input wire logic irSelect,
    input wire logic txSerial,
    input wire logic irTxEncN,
    output logic serialTxPin,
    output logic irTxPinN,
    input wire logic serialRxPin,
    input wire logic irRxPin,
    output logic rxToReceiver,
    output logic irRxToDecoder,
    input wire logic terminalReadyN,
    input wire logic requestToSendN,
    input wire logic userOutputOneN,
    input wire logic userOutputTwoN,
    output logic terminalReadyOutN,
    output logic requestToSendOutN,
    output logic userOutputOneOutN,
    output logic userOutputTwoOutN,
    input wire logic setReadyPinN,
    input wire logic clearToSendPinN,
    input wire logic ringIndicatorPinN,
    input wire logic carrierDetectPinN,
    output logic setReadyInN,
    output logic clearToSendInN,
    output logic ringIndicatorInN,
    output logic carrierDetectInN,
    input wire logic rxPush,
    input wire logic rxParityErr,
    input wire logic rxStopBitOk,
    input wire logic rxBreak,
    input wire logic rxPop,
    input wire logic txFifoEmpty,
    input wire logic holdingEmpty,
    input wire logic shiftEmpty
);
    localparam int unsigned DW = ulbls_pkg::DATA_WIDTH;
    localparam int unsigned IW = ulbls_pkg::IRQ_WIDTH;

    typedef struct packed {
        logic loopback;
        logic [DW-1:0] rdData;
        logic [IW-1:0] irqStatus;
        logic [IW-1:0] irqMask;
        logic irq;
        logic rxErrPrev;
        logic temtPrev;
        logic serialTx;
        logic irTxN;
        logic rxOut;
        logic irRxOut;
        logic [3:0] modemOut;
        logic [3:0] modemIn;
    } ulbls_top_state_type;

    ulbls_top_state_type r;
    ulbls_top_state_type rNxt;
    logic selMcr;
    logic selLsr;
    logic selStatus;
    logic selMask;
    logic rxErrRaw;
    logic rxErrFlag;
    logic temtFlag;
    logic [IW-1:0] events;
    logic [IW-1:0] clearBits;
    logic [DW-1:0] lsrValue;
    logic [DW-1:0] mcrValue;
    logic [3:0] modemCore;
    logic [3:0] modemPins;

    assign selMcr = (regAddr == ulbls_pkg::MODEM_LINE_CONTROL_ADDR);
    assign selLsr = (regAddr == ulbls_pkg::LINE_CONDITION_FLAGS_ADDR);
    assign selStatus = (regAddr == ulbls_pkg::IRQ_STATUS_ADDR);
    assign selMask = (regAddr == ulbls_pkg::IRQ_MASK_ADDR);

    ulbls_rx_err #(
        .DEPTH(RX_DEPTH)
    ) u_rxErr (
        .clk(clk),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .push(rxPush),
        .pushParityErr(rxParityErr),
        .pushStopBitOk(rxStopBitOk),
        .pushBreak(rxBreak),
        .pop(rxPop),
        .statusRead(regRd && selLsr && fifoEnable),
        .errFlag(rxErrRaw)
    );

    ulbls_tx_empty u_txEmpty (
        .clk(clk),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .fifoEnable(fifoEnable),
        .txFifoEmpty(txFifoEmpty),
        .holdingEmpty(holdingEmpty),
        .shiftEmpty(shiftEmpty),
        .emptyFlag(temtFlag)
    );

    // Flag has no meaning without FIFOs, so it reads zero then
    assign rxErrFlag = rxErrRaw & fifoEnable;

    always_comb begin
        lsrValue = '0;
        lsrValue[ulbls_pkg::RX_FIFO_ERROR_BIT] = rxErrFlag;
        lsrValue[ulbls_pkg::TRANSMITTER_EMPTY_BIT] = temtFlag;
        mcrValue = '0;
        mcrValue[ulbls_pkg::LOOPBACK_BIT] = r.loopback;
    end

    assign modemCore = {userOutputTwoN, userOutputOneN, requestToSendN,
        terminalReadyN};
    assign modemPins = {carrierDetectPinN, ringIndicatorPinN,
        clearToSendPinN, setReadyPinN};

    always_comb begin
        events = '0;
        events[ulbls_pkg::IRQ_RX_ERROR_BIT] = rxErrFlag & ~r.rxErrPrev;
        events[ulbls_pkg::IRQ_TX_EMPTY_BIT] = temtFlag & ~r.temtPrev;
        clearBits = '0;
        if (regWr && selStatus) begin
            clearBits = regWrData[IW-1:0];
        end
    end

    always_comb begin
        rNxt = r;
        rNxt.rxErrPrev = rxErrFlag;
        rNxt.temtPrev = temtFlag;
        if (regWr && selMcr) begin
            rNxt.loopback = regWrData[ulbls_pkg::LOOPBACK_BIT];
        end
        if (regWr && selMask) begin
            rNxt.irqMask = regWrData[IW-1:0];
        end
        // Events never depend on loopback; a set beats a clear
        rNxt.irqStatus = (r.irqStatus & ~clearBits) | events;
        rNxt.irq = |(rNxt.irqStatus & rNxt.irqMask);
        rNxt.rdData = '0;
        if (regRd) begin
            if (selMcr) begin
                rNxt.rdData = mcrValue;
            end else if (selLsr) begin
                rNxt.rdData = lsrValue;
            end else if (selStatus) begin
                rNxt.rdData = DW'(r.irqStatus);
            end else if (selMask) begin
                rNxt.rdData = DW'(r.irqMask);
            end
        end
        // Modem output pins always carry core outputs; loopback only taps them
        rNxt.modemOut = modemCore;
        rNxt.serialTx = txSerial;
        rNxt.irTxN = irTxEncN;
        rNxt.rxOut = serialRxPin;
        rNxt.irRxOut = irRxPin;
        rNxt.modemIn = modemPins;
        if (r.loopback) begin
            rNxt.modemIn = modemCore;
            if (irSelect) begin
                rNxt.irTxN = 1'b0;
                rNxt.irRxOut = ~txSerial;
            end else begin
                rNxt.serialTx = 1'b1;
                rNxt.rxOut = txSerial;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
            r.loopback <= ulbls_pkg::LOOPBACK_RESET;
            r.serialTx <= 1'b1;
            r.irTxN <= 1'b1;
            r.rxOut <= 1'b1;
            r.modemOut <= 4'hF;
            r.modemIn <= 4'hF;
            r.temtPrev <= ulbls_pkg::TRANSMITTER_EMPTY_RESET;
        end else if (clkEn) begin
            r <= rNxt;
        end
    end

    assign regRdData = r.rdData;
    assign irq = r.irq;
    assign loopbackActive = r.loopback;
    assign serialTxPin = r.serialTx;
    assign irTxPinN = r.irTxN;
    assign rxToReceiver = r.rxOut;
    assign irRxToDecoder = r.irRxOut;
    assign terminalReadyOutN = r.modemOut[0];
    assign requestToSendOutN = r.modemOut[1];
    assign userOutputOneOutN = r.modemOut[2];
    assign userOutputTwoOutN = r.modemOut[3];
    assign setReadyInN = r.modemIn[0];
    assign clearToSendInN = r.modemIn[1];
    assign ringIndicatorInN = r.modemIn[2];
    assign carrierDetectInN = r.modemIn[3];

    property p_loopbackWrite;
        @(posedge clk) disable iff (!reset_n)
        (clkEn && regWr && selMcr)
            |=> loopbackActive == $past(regWrData[ulbls_pkg::LOOPBACK_BIT]);
    endproperty
    a_loopbackWrite: assert property (p_loopbackWrite)
        else $error("loopback bit did not follow the write");

    property p_plainLoop;
        @(posedge clk) disable iff (!reset_n)
        (clkEn && r.loopback && !irSelect)
            |=> (serialTxPin && rxToReceiver == $past(txSerial));
    endproperty
    a_plainLoop: assert property (p_plainLoop)
        else $error("plain loopback path wrong");

    property p_irLoop;
        @(posedge clk) disable iff (!reset_n)
        (clkEn && r.loopback && irSelect)
            |=> (!irTxPinN && irRxToDecoder == !$past(txSerial));
    endproperty
    a_irLoop: assert property (p_irLoop)
        else $error("infrared loopback path wrong");

    property p_modemLoop;
        @(posedge clk) disable iff (!reset_n)
        (clkEn && r.loopback)
            |=> (setReadyInN == $past(terminalReadyN)
                && carrierDetectInN == $past(userOutputTwoN)
                && ringIndicatorInN == $past(userOutputOneN)
                && clearToSendInN == $past(requestToSendN));
    endproperty
    a_modemLoop: assert property (p_modemLoop)
        else $error("modem inputs not fed from outputs in loopback");

    property p_irqLevel;
        @(posedge clk) disable iff (!reset_n)
        irq == |(r.irqStatus & r.irqMask);
    endproperty
    a_irqLevel: assert property (p_irqLevel)
        else $error("interrupt level disagrees with status and mask");

    property p_lsrRfe;
        @(posedge clk) disable iff (!reset_n)
        (clkEn && regRd && selLsr)
            |=> (regRdData[ulbls_pkg::RX_FIFO_ERROR_BIT]
                    == $past(rxErrRaw && fifoEnable)
                && regRdData[15:8] == 8'h00);
    endproperty
    a_lsrRfe: assert property (p_lsrRfe)
        else $error("receive error bit read wrong");

    property p_lsrTemt;
        @(posedge clk) disable iff (!reset_n)
        (clkEn && regRd && selLsr)
            |=> regRdData[ulbls_pkg::TRANSMITTER_EMPTY_BIT]
                == $past(temtFlag);
    endproperty
    a_lsrTemt: assert property (p_lsrTemt)
        else $error("transmitter empty bit read wrong");

    property p_temtNoFifo;
        @(posedge clk) disable iff (!reset_n)
        (clkEn && !fifoEnable && !holdingEmpty) |=> !temtFlag;
    endproperty
    a_temtNoFifo: assert property (p_temtNoFifo)
        else $error("empty flag set with holding register full");

    property p_mcrReserved;
        @(posedge clk) disable iff (!reset_n)
        (clkEn && regRd && selMcr)
            |=> (regRdData & ~(DW'(1) << ulbls_pkg::LOOPBACK_BIT)) == '0;
    endproperty
    a_mcrReserved: assert property (p_mcrReserved)
        else $error("reserved control bits read nonzero");

    // A clear in the same cycle must not swallow the event
    property p_statusSet;
        @(posedge clk) disable iff (!reset_n)
        (clkEn && temtFlag && !r.temtPrev)
            |=> r.irqStatus[ulbls_pkg::IRQ_TX_EMPTY_BIT];
    endproperty
    a_statusSet: assert property (p_statusSet)
        else $error("transmitter empty rise did not set status");

    property p_rfeGate;
        @(posedge clk) disable iff (!reset_n)
        (clkEn && regRd && selLsr && !fifoEnable)
            |=> !regRdData[ulbls_pkg::RX_FIFO_ERROR_BIT];
    endproperty
    a_rfeGate: assert property (p_rfeGate)
        else $error("receive error bit shown with fifos off");
endmodule
`default_nettype wire

// file: verif/ulbls_remote.sv
// Model of the remote serial device on the receive and modem pins
`timescale 1ns/1ps
`default_nettype none
module ulbls_remote (
    input wire logic clk,
    input wire logic reset_n,
    output logic serialRxPin,
    output logic irRxPin,
    output logic setReadyPinN,
    output logic clearToSendPinN,
    output logic ringIndicatorPinN,
    output logic carrierDetectPinN
);
    logic [5:0] cnt_r;
    // Lines keep moving so an ignored pin cannot match by luck
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= 6'h2A;
        end else begin
            cnt_r <= cnt_r + 6'h07;
        end
    end
    assign serialRxPin = cnt_r[0];
    assign irRxPin = cnt_r[1];
    assign setReadyPinN = cnt_r[2];
    assign clearToSendPinN = cnt_r[3];
    assign ringIndicatorPinN = cnt_r[4];
    assign carrierDetectPinN = cnt_r[5];
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the loopback and line status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [31:0] MCTL_A = ulbls_pkg::MODEM_LINE_CONTROL_ADDR;
    localparam logic [31:0] FLAGS_A = ulbls_pkg::LINE_CONDITION_FLAGS_ADDR;
    localparam logic [31:0] STAT_A = ulbls_pkg::IRQ_STATUS_ADDR;
    localparam logic [31:0] MASK_A = ulbls_pkg::IRQ_MASK_ADDR;
    // Fifo enable, fifo empty, holding empty, shifter empty, expected
    localparam logic [4:0] TEMT_TBL [7] = '{5'h16, 5'h1B, 5'h1C, 5'h0A,
        5'h07, 5'h0C, 5'h0F};
    logic clk = 1'b0;
    logic reset_n, clkEn, regWr, regRd, fifoEnable, irSelect, txSerial;
    logic irTxEncN, terminalReadyN, requestToSendN, userOutputOneN;
    logic userOutputTwoN, rxPush, rxParityErr, rxStopBitOk, rxBreak, rxPop;
    logic txFifoEmpty, holdingEmpty, shiftEmpty, irq, loopbackActive;
    logic [31:0] regAddr;
    logic [15:0] regWrData, regRdData;
    logic serialRxPin, irRxPin, setReadyPinN, clearToSendPinN;
    logic ringIndicatorPinN, carrierDetectPinN, serialTxPin, irTxPinN;
    logic rxToReceiver, irRxToDecoder, terminalReadyOutN, requestToSendOutN;
    logic userOutputOneOutN, userOutputTwoOutN, setReadyInN, clearToSendInN;
    logic ringIndicatorInN, carrierDetectInN;
    int err_count = 0;
    int checks = 0;

    always #2.5 clk = ~clk;

    // Small receive depth keeps the error bookkeeping short
    ulbls_top #(.RX_DEPTH(4)) u_dut (.clk, .reset_n, .clkEn, .regAddr,
        .regWrData, .regWr, .regRd, .regRdData, .irq, .loopbackActive,
        .fifoEnable, .irSelect, .txSerial, .irTxEncN, .serialTxPin,
        .irTxPinN, .serialRxPin, .irRxPin, .rxToReceiver, .irRxToDecoder,
        .terminalReadyN, .requestToSendN, .userOutputOneN, .userOutputTwoN,
        .terminalReadyOutN, .requestToSendOutN, .userOutputOneOutN,
        .userOutputTwoOutN, .setReadyPinN, .clearToSendPinN,
        .ringIndicatorPinN, .carrierDetectPinN, .setReadyInN,
        .clearToSendInN, .ringIndicatorInN, .carrierDetectInN, .rxPush,
        .rxParityErr, .rxStopBitOk, .rxBreak, .rxPop, .txFifoEmpty,
        .holdingEmpty, .shiftEmpty);

    ulbls_remote u_remote (.clk, .reset_n, .serialRxPin, .irRxPin,
        .setReadyPinN, .clearToSendPinN, .ringIndicatorPinN,
        .carrierDetectPinN);

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chkBit(input string what, input logic exp,
                          input logic got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rdChk(input logic [31:0] a, input logic [15:0] exp,
                         input string what);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk(what, exp, regRdData);
        @(posedge clk);
    endtask

    task automatic chkIrq(input logic exp);
        repeat (3) @(posedge clk);
        #1;
        chkBit("irq", exp, irq);
        @(posedge clk);
    endtask

    task automatic push(input logic par, input logic stopOk, input logic brk);
        rxPush <= 1'b1;
        rxParityErr <= par;
        rxStopBitOk <= stopOk;
        rxBreak <= brk;
        @(posedge clk);
        rxPush <= 1'b0;
        @(posedge clk);
    endtask

    task automatic pop;
        rxPop <= 1'b1;
        @(posedge clk);
        rxPop <= 1'b0;
        @(posedge clk);
    endtask

    // Outputs registered once: compare just after the sampling edge
    task automatic pathChk(input logic lb, input logic ir);
        logic tx, enc, rp, ip;
        logic [3:0] core, pins;
        @(posedge clk);
        tx = txSerial;
        enc = irTxEncN;
        rp = serialRxPin;
        ip = irRxPin;
        core = {terminalReadyN, requestToSendN, userOutputOneN,
                userOutputTwoN};
        pins = {setReadyPinN, clearToSendPinN, ringIndicatorPinN,
                carrierDetectPinN};
        #1;
        chkBit("loopback", lb, loopbackActive);
        chkBit("tx pin", (lb && !ir) | tx, serialTxPin);
        chkBit("ir tx pin", enc & !(lb && ir), irTxPinN);
        if (!(lb && ir)) chkBit("rx path", lb ? tx : rp, rxToReceiver);
        if (!lb || ir) chkBit("ir rx", lb ? !tx : ip, irRxToDecoder);
        chk("modem in", {12'h000, lb ? core : pins}, {12'h000, setReadyInN,
            clearToSendInN, ringIndicatorInN, carrierDetectInN});
        chk("modem out", {12'h000, core}, {12'h000, terminalReadyOutN,
            requestToSendOutN, userOutputOneOutN, userOutputTwoOutN});
        @(posedge clk);
    endtask

    task automatic t_regs;
        rdChk(MCTL_A, 16'h0000, "control reset");
        rdChk(FLAGS_A, 16'h0040, "flags reset");
        rdChk(STAT_A, 16'h0000, "status reset");
        rdChk(MASK_A, 16'h0000, "mask reset");
        rdChk(32'h50001118, 16'h0000, "unmapped");
        clkEn <= 1'b0;
        wr(MCTL_A, 16'h0010);
        clkEn <= 1'b1;
        rdChk(MCTL_A, 16'h0000, "frozen write");
        wr(MCTL_A, 16'hFFFF);
        rdChk(MCTL_A, 16'h0010, "control reserved");
        wr(FLAGS_A, 16'hFFFF);
        rdChk(FLAGS_A, 16'h0040, "flags read only");
        wr(MCTL_A, 16'h0000);
        rdChk(MCTL_A, 16'h0000, "loopback off");
    endtask

    task automatic t_paths;
        logic [1:0] mode;
        logic [5:0] i;
        for (int m = 0; m < 4; m++) begin
            mode = 2'(m);
            irSelect <= mode[0];
            wr(MCTL_A, mode[1] ? 16'h0010 : 16'h0000);
            for (int k = 0; k < 6; k++) begin
                i = 6'(k * 13 + m);
                {txSerial, irTxEncN} <= i[1:0];
                {terminalReadyN, requestToSendN} <= i[3:2];
                {userOutputOneN, userOutputTwoN} <= i[5:4];
                pathChk(mode[1], mode[0]);
            end
        end
        irSelect <= 1'b0;
    endtask

    task automatic t_temt;
        for (int i = 0; i < 7; i++) begin
            {fifoEnable, txFifoEmpty, holdingEmpty, shiftEmpty} <=
                TEMT_TBL[i][4:1];
            repeat (2) @(posedge clk);
            rdChk(FLAGS_A, {9'h000, TEMT_TBL[i][0], 6'h00},
                  "transmitter empty");
        end
    endtask

    // The transmitter empty interrupt must keep working while looped back
    task automatic t_irq;
        wr(MCTL_A, 16'h0010);
        wr(MASK_A, 16'h0003);
        rdChk(MASK_A, 16'h0003, "mask");
        wr(STAT_A, 16'h0003);
        shiftEmpty <= 1'b0;
        chkIrq(1'b0);
        shiftEmpty <= 1'b1;
        chkIrq(1'b1);
        rdChk(STAT_A, 16'h0002, "status empty rose");
        wr(MASK_A, 16'h0001);
        chkIrq(1'b0);
        wr(MASK_A, 16'h0003);
        chkIrq(1'b1);
        wr(STAT_A, 16'h0002);
        chkIrq(1'b0);
        rdChk(STAT_A, 16'h0000, "status cleared");
        wr(MCTL_A, 16'h0000);
    endtask

    task automatic t_rxerr;
        fifoEnable <= 1'b1;
        push(1'b0, 1'b1, 1'b0);
        rdChk(FLAGS_A, 16'h0040, "clean char");
        push(1'b0, 1'b0, 1'b0);
        rdChk(FLAGS_A, 16'h00C0, "framing error");
        rdChk(FLAGS_A, 16'h00C0, "error not at head");
        pop;
        rdChk(FLAGS_A, 16'h00C0, "error at head");
        rdChk(FLAGS_A, 16'h0040, "cleared by read");
        pop;
        push(1'b1, 1'b1, 1'b0);
        push(1'b0, 1'b1, 1'b1);
        rdChk(FLAGS_A, 16'h00C0, "parity error");
        rdChk(FLAGS_A, 16'h00C0, "later error kept");
        pop;
        rdChk(FLAGS_A, 16'h00C0, "break at head");
        rdChk(FLAGS_A, 16'h0040, "break cleared");
        pop;
        fifoEnable <= 1'b0;
        push(1'b1, 1'b1, 1'b0);
        rdChk(FLAGS_A, 16'h0040, "fifo disabled");
        fifoEnable <= 1'b1;
        @(posedge clk);
        rdChk(FLAGS_A, 16'h00C0, "fifo enabled again");
        rdChk(STAT_A, 16'h0001, "status error rose");
        chkIrq(1'b1);
    endtask

    initial begin
        reset_n = 1'b0;
        clkEn = 1'b1;
        {regWr, regRd, irSelect, rxPush, rxParityErr, rxBreak, rxPop} = '0;
        regAddr = 32'h00000000;
        regWrData = 16'h0000;
        {fifoEnable, txFifoEmpty, holdingEmpty, shiftEmpty} = 4'hF;
        {txSerial, irTxEncN, rxStopBitOk} = 3'h7;
        {terminalReadyN, requestToSendN} = 2'h3;
        {userOutputOneN, userOutputTwoN} = 2'h3;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        t_regs;
        t_paths;
        t_temt;
        t_irq;
        t_rxerr;
        give_verdict;
    end

    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        give_verdict;
    end
endmodule
`default_nettype wire
